// File: pkg/tmas_consts.svh
/*
 Constants of the two-channel temperature monitor core: command codes,
 reset values, status bit positions, alert-response address and timing.
 Assumes inclusion by the register file and core modules.
*/
`ifndef TMAS_CONSTS_SVH
`define TMAS_CONSTS_SVH
// Command codes
`define TMAS_CMD_LOCAL_TEMP 8'h00
`define TMAS_CMD_REMOTE_TEMP 8'h01
`define TMAS_CMD_STATUS 8'h02
`define TMAS_CMD_CFG_RD 8'h03
`define TMAS_CMD_RATE_RD 8'h04
`define TMAS_CMD_LHL_RD 8'h05
`define TMAS_CMD_LLL_RD 8'h06
`define TMAS_CMD_RHL_RD 8'h07
`define TMAS_CMD_RLL_RD 8'h08
`define TMAS_CMD_CFG_WR 8'h09
`define TMAS_CMD_RATE_WR 8'h0a
`define TMAS_CMD_LHL_WR 8'h0b
`define TMAS_CMD_LLL_WR 8'h0c
`define TMAS_CMD_RHL_WR 8'h0d
`define TMAS_CMD_RLL_WR 8'h0e
`define TMAS_CMD_ONESHOT 8'h0f
// Reset values and diode-fault reading
`define TMAS_RST_HIGH_LIMIT 8'h7f
`define TMAS_RST_LOW_LIMIT 8'hc9
`define TMAS_RST_RATE 8'h02
`define TMAS_RST_POINTER 8'h00
`define TMAS_RST_CFG 8'h00
`define TMAS_DIODE_FAULT_TEMP 8'h7f
// Configuration and status bit positions
`define TMAS_CFG_MASK_BIT 7
`define TMAS_CFG_HW_SLEEP_PIN_BIT 6
`define TMAS_ST_BUSY_BIT 7
`define TMAS_ST_LHI_BIT 6
`define TMAS_ST_LLO_BIT 5
`define TMAS_ST_RHI_BIT 4
`define TMAS_ST_RLO_BIT 3
`define TMAS_ST_OPEN_BIT 2
// Alert-response address, 7 bits
`define TMAS_ARA_ADDR 7'h0c
// Conversion time in microseconds and its cycle count at 10 MHz
`define TMAS_CONV_TIME_US 170000
`define TMAS_CLK_MHZ 10
`define TMAS_CONV_CYCLES (`TMAS_CONV_TIME_US * `TMAS_CLK_MHZ)
`endif

// File: pkg/tmas_pkg.sv
/*
 Types of the temperature monitor core.
 Assumes the constants header is on the include path.
*/
package tmas_pkg;
   // Analogue front-end result handed to the core
   typedef struct packed {
      logic [7:0] local_temp;  // Local reading, two's complement
      logic [7:0] remote_temp; // Remote reading, two's complement
      logic diode_open;        // Remote diode open
      logic diode_short;       // Remote diode shorted
   } tmas_adc_t;
   // Serial transfer engine states
   typedef enum logic [2:0] {
      TMAS_IDLE = 3'b000,
      TMAS_ADDR = 3'b001,
      TMAS_AACK = 3'b010,
      TMAS_WBYTE = 3'b011,
      TMAS_WACK = 3'b100,
      TMAS_RBYTE = 3'b101,
      TMAS_RACK = 3'b110,
      TMAS_SKIP = 3'b111
   } tmas_state_t;
endpackage

// File: core/tmas_regfile.sv
/*
 Limit and configuration storage of the temperature monitor: four limit
 bytes, configuration and rate, with a registered read port.
 Assumes one clock and a synchronised active-low reset.
*/
`timescale 1ns/1ps
`include "tmas_consts.svh"
module tmas_regfile (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wr_en_in,       // One-cycle write strobe
   input wire logic [7:0] wr_cmd_in, // Write command code
   input wire logic [7:0] wr_data_in,
   input wire logic [7:0] rd_cmd_in, // Read command code
   output logic [7:0] rd_data_out,  // Registered read data
   output logic [7:0] lhl_out,
   output logic [7:0] lll_out,
   output logic [7:0] rhl_out,
   output logic [7:0] rll_out,
   output logic [7:0] cfg_out,
   output logic [7:0] rate_out
);
   logic [7:0] mem_ff [0:5]; // 0..3 limits, 4 cfg, 5 rate
   // Writes, reset to documented defaults
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mem_ff[0] <= `TMAS_RST_HIGH_LIMIT;
         mem_ff[1] <= `TMAS_RST_LOW_LIMIT;
         mem_ff[2] <= `TMAS_RST_HIGH_LIMIT;
         mem_ff[3] <= `TMAS_RST_LOW_LIMIT;
         mem_ff[4] <= `TMAS_RST_CFG;
         mem_ff[5] <= `TMAS_RST_RATE;
      end else if (wr_en_in) begin
         case (wr_cmd_in)
            `TMAS_CMD_LHL_WR: mem_ff[0] <= wr_data_in;
            `TMAS_CMD_LLL_WR: mem_ff[1] <= wr_data_in;
            `TMAS_CMD_RHL_WR: mem_ff[2] <= wr_data_in;
            `TMAS_CMD_RLL_WR: mem_ff[3] <= wr_data_in;
            `TMAS_CMD_CFG_WR: mem_ff[4] <= {wr_data_in[7:6], 6'h00};
            `TMAS_CMD_RATE_WR: mem_ff[5] <= {5'h00, wr_data_in[2:0]};
            default: ;
         endcase
      end
   end
   // Registered read port
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= 8'h00;
      end else begin
         case (rd_cmd_in)
            `TMAS_CMD_LHL_RD: rd_data_out <= mem_ff[0];
            `TMAS_CMD_LLL_RD: rd_data_out <= mem_ff[1];
            `TMAS_CMD_RHL_RD: rd_data_out <= mem_ff[2];
            `TMAS_CMD_RLL_RD: rd_data_out <= mem_ff[3];
            `TMAS_CMD_CFG_RD: rd_data_out <= mem_ff[4];
            `TMAS_CMD_RATE_RD: rd_data_out <= mem_ff[5];
            default: rd_data_out <= 8'h00;
         endcase
      end
   end
   assign lhl_out = mem_ff[0];
   assign lll_out = mem_ff[1];
   assign rhl_out = mem_ff[2];
   assign rll_out = mem_ff[3];
   assign cfg_out = mem_ff[4];
   assign rate_out = mem_ff[5];
endmodule

// File: core/tmas_core.sv
/*
 Digital core of a two-channel temperature monitor with a serial slave,
 limit alarms, sticky status, conversion control and a latched alert.
 Assumes an analogue front end supplying readings and diode state, and
 serial clock and data pins arriving asynchronously to clk_in.
*/
`timescale 1ns/1ps
`include "tmas_consts.svh"
module tmas_core #(
   parameter logic [6:0] SLAVE_ADDR = 7'h4c,           // Own address, arbitrary default
   parameter int CONV_CYCLES = `TMAS_CONV_CYCLES,      // Conversion duration in cycles
   parameter int RATE_BASE_CYCLES = 160000000          // Period at rate code 0 (16 s)
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic serial_clk_in,          // Bus clock pin
   input wire logic serial_data_pin_in,     // Bus data pin level
   output logic serial_data_pin_out,        // Data drive value, always low
   output logic serial_data_pin_oe_out,     // High while pulling data low
   input wire logic hw_sleep_pin_n_in,      // Low selects hardware standby
   input wire tmas_pkg::tmas_adc_t adc_in,  // Front-end result
   output logic alert_n_out,                // Alert drive value, always low
   output logic alert_oe_out,               // High while alert pulled low
   output logic conv_start_out,             // Pulse: front end starts
   output logic [7:0] local_temp_reading_out,
   output logic [7:0] remote_temp_reading_out
);
   import tmas_pkg::*;
   logic [1:0] rst_sync_ff;   // Reset release chain
   logic rst_n;
   logic [1:0] scl_sync_ff, sda_sync_ff, slp_sync_ff; // Pin synchronisers
   logic scl_d_ff, sda_d_ff;  // Delayed samples for edges
   logic scl_rise, scl_fall, start_cond, stop_cond;
   tmas_state_t state_ff;
   logic [3:0] bit_cnt_ff;    // Bits within a byte
   logic [7:0] shift_ff;      // Shift register
   logic is_ara_ff;           // Current transfer is alert response
   logic got_cmd_ff, got_data_ff; // Command and data byte seen in this transfer
   logic [7:0] pointer_ff;    // Register pointer
   logic [7:0] tx_ff;         // Byte being sent
   logic wr_en_ff;            // Register write strobe
   logic [7:0] wr_data_ff;
   logic stat_read_ff;        // Status byte sent, pulse at its acknowledge clock rise
   logic ara_read_ff;         // Alert-response byte sent
   logic oneshot_ff;          // One-shot request pulse
   logic [7:0] rf_rd_data, lhl, lll, rhl, rll, cfg, rate;
   logic busy_ff;
   logic [31:0] conv_cnt_ff, rate_cnt_ff;
   logic [7:0] ltemp_ff, rtemp_ff;
   logic [4:0] flags_ff;      // Sticky {lhi,llo,rhi,rlo,open}
   logic [4:0] cond;          // Live fault conditions
   logic conv_done;
   logic alert_ff;
   logic [7:0] status_byte;
   logic sleep;
   // Reset release through two flip-flops
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];
   // Pin synchronisers and edge history
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync_ff <= 2'b11;
         sda_sync_ff <= 2'b11;
         slp_sync_ff <= 2'b11;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[0], serial_clk_in};
         sda_sync_ff <= {sda_sync_ff[0], serial_data_pin_in};
         slp_sync_ff <= {slp_sync_ff[0], hw_sleep_pin_n_in};
         scl_d_ff <= scl_sync_ff[1];
         sda_d_ff <= sda_sync_ff[1];
      end
   end
   assign scl_rise = scl_sync_ff[1] & ~scl_d_ff;
   assign scl_fall = ~scl_sync_ff[1] & scl_d_ff;
   assign start_cond = scl_sync_ff[1] & scl_d_ff & sda_d_ff & ~sda_sync_ff[1];
   assign stop_cond = scl_sync_ff[1] & scl_d_ff & ~sda_d_ff & sda_sync_ff[1];
   assign sleep = ~slp_sync_ff[1];
   // Status byte as read
   assign status_byte = {busy_ff, flags_ff, 2'b00};
   // Serial slave engine: nine clocks per byte
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= TMAS_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         is_ara_ff <= 1'b0;
         got_cmd_ff <= 1'b0;
         got_data_ff <= 1'b0;
         pointer_ff <= `TMAS_RST_POINTER;
         tx_ff <= 8'h00;
         wr_en_ff <= 1'b0;
         wr_data_ff <= 8'h00;
         stat_read_ff <= 1'b0;
         ara_read_ff <= 1'b0;
         oneshot_ff <= 1'b0;
         serial_data_pin_oe_out <= 1'b0;
      end else begin
         wr_en_ff <= 1'b0;
         stat_read_ff <= 1'b0;
         ara_read_ff <= 1'b0;
         oneshot_ff <= 1'b0;
         if (start_cond) begin
            // Start or repeated start
            state_ff <= TMAS_ADDR;
            bit_cnt_ff <= 4'h0;
            got_cmd_ff <= 1'b0;
            got_data_ff <= 1'b0;
            serial_data_pin_oe_out <= 1'b0;
         end else if (stop_cond) begin
            // Send byte acts at stop; the stop's own clock rise counts one bit
            if (state_ff == TMAS_WBYTE && got_cmd_ff && !got_data_ff && bit_cnt_ff <= 4'h1 &&
                pointer_ff == `TMAS_CMD_ONESHOT) begin
               oneshot_ff <= 1'b1;
            end
            state_ff <= TMAS_IDLE;
            serial_data_pin_oe_out <= 1'b0;
         end else begin
            case (state_ff)
               TMAS_IDLE: ;
               TMAS_ADDR: begin
                  if (scl_rise) begin
                     shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                     bit_cnt_ff <= 4'h0;
                     if (shift_ff[7:1] == SLAVE_ADDR ||
                         (shift_ff[7:1] == `TMAS_ARA_ADDR && shift_ff[0] && alert_ff)) begin
                        is_ara_ff <= (shift_ff[7:1] == `TMAS_ARA_ADDR);
                        serial_data_pin_oe_out <= 1'b1; // Acknowledge address
                        state_ff <= TMAS_AACK;
                     end else begin
                        state_ff <= TMAS_SKIP;
                     end
                  end
               end
               TMAS_AACK: begin
                  if (scl_fall) begin
                     if (shift_ff[0]) begin
                        // Read: alert response or selected register
                        if (is_ara_ff) begin
                           tx_ff <= {SLAVE_ADDR, 1'b1};
                        end else if (pointer_ff == `TMAS_CMD_LOCAL_TEMP) begin
                           tx_ff <= ltemp_ff;
                        end else if (pointer_ff == `TMAS_CMD_REMOTE_TEMP) begin
                           tx_ff <= rtemp_ff;
                        end else if (pointer_ff == `TMAS_CMD_STATUS) begin
                           tx_ff <= status_byte;
                        end else begin
                           tx_ff <= rf_rd_data;
                        end
                        serial_data_pin_oe_out <= 1'b0;
                        state_ff <= TMAS_RBYTE;
                     end else begin
                        serial_data_pin_oe_out <= 1'b0;
                        state_ff <= TMAS_WBYTE;
                     end
                  end
               end
               TMAS_WBYTE: begin
                  if (scl_rise) begin
                     shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                     bit_cnt_ff <= 4'h0;
                     serial_data_pin_oe_out <= 1'b1; // Acknowledge byte
                     state_ff <= TMAS_WACK;
                     if (!got_cmd_ff) begin
                        pointer_ff <= shift_ff; // Command byte
                        got_cmd_ff <= 1'b1;
                     end else begin
                        wr_data_ff <= shift_ff; // Data byte
                        got_data_ff <= 1'b1;
                        wr_en_ff <= 1'b1;
                     end
                  end
               end
               TMAS_WACK: begin
                  if (scl_fall) begin
                     serial_data_pin_oe_out <= 1'b0;
                     state_ff <= TMAS_WBYTE;
                  end
               end
               TMAS_RBYTE: begin
                  // Drive bit on falling edge, MSB first
                  serial_data_pin_oe_out <= ~tx_ff[7];
                  if (scl_fall) begin
                     if (bit_cnt_ff == 4'h7) begin
                        state_ff <= TMAS_RACK;
                        bit_cnt_ff <= 4'h0;
                        serial_data_pin_oe_out <= 1'b0;
                     end else begin
                        tx_ff <= {tx_ff[6:0], 1'b0};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     end
                  end
               end
               TMAS_RACK: begin
                  if (scl_rise) begin
                     // Byte delivered; read ends at this clock rise whether the host ACKs or NACKs
                     stat_read_ff <= ~is_ara_ff & (pointer_ff == `TMAS_CMD_STATUS);
                     ara_read_ff <= is_ara_ff;
                     state_ff <= TMAS_SKIP;
                  end
               end
               TMAS_SKIP: ;
               default: state_ff <= TMAS_IDLE;
            endcase
         end
      end
   end
   assign serial_data_pin_out = 1'b0;
   // Register storage
   tmas_regfile u_regfile (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .wr_en_in(wr_en_ff),
      .wr_cmd_in(pointer_ff),
      .wr_data_in(wr_data_ff),
      .rd_cmd_in(pointer_ff),
      .rd_data_out(rf_rd_data),
      .lhl_out(lhl),
      .lll_out(lll),
      .rhl_out(rhl),
      .rll_out(rll),
      .cfg_out(cfg),
      .rate_out(rate)
   );
   // Conversion sequencer
   assign conv_done = busy_ff && (conv_cnt_ff == 32'(CONV_CYCLES - 1));
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
         conv_cnt_ff <= 32'h0;
         rate_cnt_ff <= 32'h0;
         conv_start_out <= 1'b0;
      end else begin
         conv_start_out <= 1'b0;
         if (sleep) begin
            // Hardware standby aborts and blocks
            busy_ff <= 1'b0;
            rate_cnt_ff <= 32'h0;
         end else if (busy_ff) begin
            conv_cnt_ff <= conv_cnt_ff + 32'h1;
            if (conv_done) begin
               busy_ff <= 1'b0; // Back to standby after one
            end
            // One-shot while busy is ignored
         end else if (oneshot_ff ||
                      (!cfg[`TMAS_CFG_HW_SLEEP_PIN_BIT] &&
                       rate_cnt_ff >= (32'(RATE_BASE_CYCLES) >> rate[2:0]))) begin
            busy_ff <= 1'b1;
            conv_cnt_ff <= 32'h0;
            rate_cnt_ff <= 32'h0;
            conv_start_out <= 1'b1;
         end else if (!cfg[`TMAS_CFG_HW_SLEEP_PIN_BIT]) begin
            rate_cnt_ff <= rate_cnt_ff + 32'h1;
         end
      end
   end
   // Readings refreshed at end; diode fault stores 127
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ltemp_ff <= 8'h00;
         rtemp_ff <= 8'h00;
      end else if (conv_done && !sleep) begin
         ltemp_ff <= adc_in.local_temp;
         rtemp_ff <= (adc_in.diode_open | adc_in.diode_short) ? `TMAS_DIODE_FAULT_TEMP
                                                              : adc_in.remote_temp;
      end
   end
   assign local_temp_reading_out = ltemp_ff;
   assign remote_temp_reading_out = rtemp_ff;
   // Live conditions: signed compare at or past limit
   always_comb begin
      cond[4] = $signed(ltemp_ff) >= $signed(lhl);
      cond[3] = $signed(ltemp_ff) <= $signed(lll);
      cond[2] = ($signed(rtemp_ff) >= $signed(rhl)) | adc_in.diode_open | adc_in.diode_short;
      cond[1] = $signed(rtemp_ff) <= $signed(rll);
      cond[0] = adc_in.diode_open;
   end
   // Sticky flags; set beats read-clear
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         flags_ff <= 5'h00;
      end else if (stat_read_ff) begin
         flags_ff <= cond;
      end else begin
         flags_ff <= flags_ff | cond;
      end
   end
   // Alert latch, cleared only by alert-response read
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         alert_ff <= 1'b0;
      end else if (ara_read_ff) begin
         alert_ff <= |cond;
      end else if (|cond) begin
         alert_ff <= 1'b1;
      end
   end
   // Open-drain alert output, masked by config
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         alert_oe_out <= 1'b0;
      end else begin
         alert_oe_out <= alert_ff & ~cfg[`TMAS_CFG_MASK_BIT];
      end
   end
   assign alert_n_out = 1'b0;
endmodule

// File: test/tmas_core_assertions.sv
/* Port-level checks of the monitor core.
   Assumes binding to every tmas_core instance. */
`timescale 1ns/1ps
module tmas_core_assertions #(
   parameter int CONV_CYCLES = 600 // Conversion length in clocks
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic serial_clk_in,
   input wire logic serial_data_pin_out,
   input wire logic serial_data_pin_oe_out,
   input wire logic hw_sleep_pin_n_in,
   input wire logic alert_n_out,
   input wire logic alert_oe_out,
   input wire logic conv_start_out,
   input wire logic [7:0] local_temp_reading_out
);
   int since_ff; // Clocks since last conversion start
   int quiet_ff; // Clocks since bus clock moved
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   // Age of the running conversion, saturating
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         since_ff <= 4 * CONV_CYCLES;
      else if (conv_start_out)
         since_ff <= 0;
      else if (since_ff < 4 * CONV_CYCLES)
         since_ff <= since_ff + 1;
   end
   // Idle span of the bus clock, saturating
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         quiet_ff <= 255;
      else if ($changed(serial_clk_in))
         quiet_ff <= 0;
      else if (quiet_ff < 255)
         quiet_ff <= quiet_ff + 1;
   end
   // Sleep pin held low long enough to be seen
   sequence asleep_s;
      !hw_sleep_pin_n_in [*6];
   endsequence
   a_alert_low: assert property (alert_n_out == 1'b0)
      else $error("alert drive value not low");
   a_alert_bus: assert property ($fell(alert_oe_out) |-> quiet_ff < 40)
      else $error("alert released without bus traffic");
   a_ack_scl_low: assert property ($changed(serial_data_pin_oe_out) |->
      !serial_clk_in && !serial_data_pin_out)
      else $error("data drive moved while bus clock high");
   a_start_pulse: assert property (conv_start_out |=> !conv_start_out)
      else $error("conversion start longer than one clock");
   a_busy_ignore: assert property (conv_start_out |-> since_ff >= CONV_CYCLES)
      else $error("conversion restarted while busy");
   a_sleep_blocks: assert property (asleep_s |-> !conv_start_out)
      else $error("conversion started in hardware standby");
   a_sleep_holds: assert property (asleep_s |-> $stable(local_temp_reading_out))
      else $error("reading changed in hardware standby");
   a_read_at_end: assert property ($changed(local_temp_reading_out) |->
      since_ff >= CONV_CYCLES - 3 && since_ff <= CONV_CYCLES + 3)
      else $error("reading changed away from conversion end");
   a_reset_quiet: assert property ($rose(reset_n_in) |-> !alert_oe_out && !serial_data_pin_oe_out)
      else $error("outputs active at reset release");
endmodule
bind tmas_core tmas_core_assertions #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
   .clk_in(clk_in), .reset_n_in(reset_n_in), .serial_clk_in(serial_clk_in),
   .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe_out(serial_data_pin_oe_out),
   .hw_sleep_pin_n_in(hw_sleep_pin_n_in), .alert_n_out(alert_n_out), .alert_oe_out(alert_oe_out),
   .conv_start_out(conv_start_out), .local_temp_reading_out(local_temp_reading_out)
);

// File: test/tmas_host_model.sv
/* Bus host model: start, stop, byte slots and four transfer kinds.
   Assumes a pulled-up data line; clock idles high between frames. */
`timescale 1ns/1ps
module tmas_host_model (
   output logic scl_out,     // Bus clock, 800 ns slots
   output logic sda_low_out, // High while pulling data low
   input wire logic sda_in   // Wired data level
);
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // One slot: 500 ns low, 300 ns high, sample mid-high
   task automatic bit_slot(input logic b, output logic s);
      #100 sda_low_out = !b;
      #400 scl_out = 1'b1;
      #150 s = sda_in;
      #150 scl_out = 1'b0;
   endtask
   // Start or repeated start, clock left low
   task automatic start_c;
      #100 sda_low_out = 1'b0;
      #400 scl_out = 1'b1;
      #400 sda_low_out = 1'b1;
      #400 scl_out = 1'b0;
   endtask
   // Stop, clock and data left high
   task automatic stop_c;
      #100 sda_low_out = 1'b1;
      #400 scl_out = 1'b1;
      #400 sda_low_out = 1'b0;
      #400;
   endtask
   // Eight bits MSB first, ninth slot acknowledge
   task automatic byte_io(input logic [7:0] d, input logic nack,
      output logic [7:0] r, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(d[i], s);
         r[i] = s;
      end
      bit_slot(nack, s);
      ack = !s;
   endtask
   // Write byte, or send byte when no data
   task automatic wr(input logic [6:0] a, input logic [7:0] c, d, input logic hd,
      output logic ok);
      logic [7:0] r;
      logic k1, k2, k3;
      k3 = 1'b1;
      start_c;
      byte_io({a, 1'b0}, 1'b1, r, k1);
      byte_io(c, 1'b1, r, k2);
      if (hd)
         byte_io(d, 1'b1, r, k3);
      stop_c;
      ok = k1 & k2 & k3;
   endtask
   // Read byte, or receive byte when no command; host NACKs data
   task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic hc,
      output logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic k1, k2, k3, j;
      k1 = 1'b1;
      k2 = 1'b1;
      start_c;
      if (hc) begin
         byte_io({a, 1'b0}, 1'b1, r, k1);
         byte_io(c, 1'b1, r, k2);
         start_c;
      end
      byte_io({a, 1'b1}, 1'b1, r, k3);
      byte_io(8'hff, 1'b1, d, j);
      stop_c;
      ok = k1 & k2 & k3;
   endtask
endmodule

// File: test/tmas_core_test.sv
/* Self-checking bench of the monitor core.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module tmas_core_test;
   import tmas_pkg::*;
   localparam logic [6:0] SA = 7'h4c; // Own address, arbitrary
   localparam int CONV = 600;
   logic clk_in = 1'b0;
   logic rst_n = 1'b0;
   logic slp_n = 1'b1;
   tmas_adc_t adc = {8'h19, 8'h1e, 2'b00};
   logic scl, hlow, oe, al_oe, cs;
   logic [7:0] lt, rt;
   wire sda = !(hlow | oe); // Pulled-up data line
   int error_cnt = 0;
   int n_compared = 0;
   int starts = 0; // Conversion starts seen
   always #50 clk_in = !clk_in;
   // Count start pulses
   always @(posedge clk_in) begin
      if (cs === 1'b1)
         starts++;
   end
   tmas_core #(.SLAVE_ADDR(SA), .CONV_CYCLES(CONV), .RATE_BASE_CYCLES(16000)) uut (
      .clk_in(clk_in), .reset_n_in(rst_n), .serial_clk_in(scl), .serial_data_pin_in(sda),
      .serial_data_pin_out(), .serial_data_pin_oe_out(oe), .hw_sleep_pin_n_in(slp_n), .adc_in(adc),
      .alert_n_out(), .alert_oe_out(al_oe), .conv_start_out(cs), .local_temp_reading_out(lt),
      .remote_temp_reading_out(rt)
   );
   tmas_host_model host (.scl_out(scl), .sda_low_out(hlow), .sda_in(sda));
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic xr(input logic [6:0] a, input logic [7:0] c, input logic hc, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      host.rd(a, c, hc, d, ok);
      chk({7'h0, ok}, 8'h1);
      chk(d, e);
   endtask
   task automatic rdx(input logic [7:0] c, e);
      xr(SA, c, 1'b1, e);
   endtask
   task automatic wrx(input logic [7:0] c, d, input logic hd);
      logic ok;
      host.wr(SA, c, d, hd, ok);
      chk({7'h0, ok}, 8'h1);
      tick(1);
   endtask
   // Wait for a start, then for its end
   task automatic wait_conv;
      int n = 0;
      while (cs !== 1'b1 && n < 9000) begin
         tick(1);
         n++;
      end
      chk(8'(n < 9000), 8'h1);
      tick(CONV + 10);
   endtask
   task automatic complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Power-on values, pointer 00, receive byte
   task automatic s_reset;
      chk(8'(al_oe), 8'h0);
      xr(SA, 8'h00, 1'b0, 8'h00);
      rdx(8'h03, 8'h00);
      rdx(8'h04, 8'h02);
      rdx(8'h10, 8'h00);
      for (int c = 5; c < 9; c++) begin
         rdx(8'(c), c[0] ? 8'h7f : 8'hc9);
      end
      wait_conv;
      rdx(8'h01, 8'h1e);
      xr(SA, 8'h00, 1'b0, 8'h1e);
   endtask
   // Trips at equality, sticky flags, latched alert
   task automatic s_limits;
      wrx(8'h0c, 8'h19, 1'b1);
      wrx(8'h0d, 8'h1e, 1'b1);
      wait_conv;
      rdx(8'h02, 8'h30);
      chk(8'(al_oe), 8'h1);
      wrx(8'h0c, 8'hc9, 1'b1);
      wrx(8'h0d, 8'h7f, 1'b1);
      wait_conv;
      rdx(8'h02, 8'h30);
      rdx(8'h02, 8'h00);
      chk(8'(al_oe), 8'h1);
      xr(7'h0c, 8'h00, 1'b0, {SA, 1'b1});
      chk(8'(al_oe), 8'h0);
   endtask
   // Open then shorted diode under alert mask
   task automatic s_diode;
      wrx(8'h09, 8'h80, 1'b1);
      adc.diode_open = 1'b1;
      wait_conv;
      rdx(8'h01, 8'h7f);
      chk(rt, 8'h7f);
      rdx(8'h02, 8'h14);
      chk(8'(al_oe), 8'h0);
      tick(1);
      adc = {8'h19, 8'h1e, 2'b01};
      wait_conv;
      rdx(8'h02, 8'h14);
      rdx(8'h02, 8'h10);
      wrx(8'h09, 8'h00, 1'b1);
      tick(3);
      chk(8'(al_oe), 8'h1);
      adc.diode_short = 1'b0;
      wait_conv;
      rdx(8'h02, 8'h10);
      xr(7'h0c, 8'h00, 1'b0, {SA, 1'b1});
      chk(8'(al_oe), 8'h0);
   endtask
   // One-shot: busy ignore, hardware abort, soft standby
   task automatic s_shot;
      int n0;
      wait_conv;
      n0 = starts;
      adc.local_temp = 8'h05;
      wrx(8'h0f, 8'h00, 1'b0);
      wrx(8'h0f, 8'h00, 1'b0);
      slp_n = 1'b0;
      tick(CONV);
      chk(8'(starts - n0), 8'h1);
      chk(lt, 8'h19);
      wrx(8'h0f, 8'h00, 1'b0);
      tick(20);
      chk(8'(starts - n0), 8'h1);
      adc.local_temp = 8'h19;
      slp_n = 1'b1;
      wrx(8'h09, 8'h40, 1'b1);
      tick(CONV + 10);
      n0 = starts;
      adc.local_temp = 8'h05;
      wrx(8'h0f, 8'h00, 1'b0);
      rdx(8'h02, 8'h80);
      chk(8'(al_oe), 8'h0);
      tick(CONV);
      chk(lt, 8'h05);
      tick(5000);
      chk(8'(starts - n0), 8'h1);
   endtask
   initial begin
      tick(6);
      rst_n = 1'b1;
      tick(6);
      s_reset;
      s_limits;
      s_diode;
      s_shot;
      complete_run;
   end
   // Hang guard
   initial begin
      #9000000;
      error_cnt++;
      $display("Error %0t: watchdog expired", $time);
      complete_run;
   end
endmodule
